/* hdl/cio_defs.svh */
// constants of the configurable i/o port block
`ifndef CIO_DEFS_SVH
`define CIO_DEFS_SVH
`define CIO_NPIN 23
`define CIO_P0_LSB 0
`define CIO_P1_LSB 8
`define CIO_P2_LSB 16
`define CIO_P3_LSB 21
`define CIO_RST_PIN 13
`define CIO_SCL_PIN 10
`define CIO_SDA_PIN 11
`define CIO_XTAL2_PIN 21
`define CIO_XTAL1_PIN 22
`define CIO_CFA_MASK 23'h7fd3ff
`define CIO_CFB_MASK 23'h7fdfff
`define CIO_CFG_RESET 23'h000000
`define CIO_LAT_RESET 23'h7fffff
`define CIO_DIS_RESET 5'h00
`define CIO_MAX_PINS 5'h17
`define CIO_IDX_LATCH 4'h0
`define CIO_IDX_CFGA 4'h1
`define CIO_IDX_CFGB 4'h2
`define CIO_IDX_PINS 4'h3
`define CIO_IDX_MISC 4'h4
`define CIO_SUB_DIS 2'h0
`define CIO_SUB_STAT 2'h1
`define CIO_CLK_INT 2'h0
`define CIO_CLK_EXT 2'h1
`define CIO_CLK_XTAL 2'h2
`endif

/* hdl/cio_pkg.sv */
// types of the configurable i/o port block
package cio_pkg;
   typedef enum logic [1:0] {CIO_INPUT, CIO_QUASI, CIO_OPEN, CIO_PUSH} cio_mode_e;
   typedef struct packed {
      logic [22:0] lat;
      logic [22:0] cfa;
      logic [22:0] cfb;
      logic [22:0] s1;
      logic [22:0] s2;
      logic [4:0] dis;
      logic [31:0] rdata;
   } cio_state_s;
   typedef struct packed {
      logic [22:0] drv;
      logic [22:0] oe;
      logic [22:0] pu;
   } cio_pad_s;
endpackage : cio_pkg

/* hdl/cio_ports.sv */
// configurable i/o ports with apb register access
`timescale 1ns/1ps
`include "cio_defs.svh"
module cio_ports (
   // clock, reset, enable
   input logic pclk,
   input logic presetn,
   input logic ce,
   // apb slave
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // option straps from configuration memory
   input logic opt_ext_reset,
   input logic [1:0] opt_clk_sel,
   // pads, flat: port0 [7:0], port1 [15:8], port2 [20:16], port3 [22:21]
   input logic [22:0] pin_in,
   output logic [22:0] pin_drv,
   output logic [22:0] pin_oe,
   output logic [22:0] pin_pu
);

   cio_pkg::cio_state_s s_q, s_d;
   cio_pkg::cio_pad_s pad;
   logic [22:0] avail;
   logic [22:0] rd_pins;
   logic [4:0] pin_count;
   logic [3:0] idx;
   logic [1:0] sub;
   logic setup, wr, hit;

   // slice one port out of a flat pin vector, unused bits zero
   function automatic logic [7:0] cio_get(input logic [22:0] v, input logic [1:0] p);
      case (p)
         2'h0: cio_get = v[7:0];
         2'h1: cio_get = v[15:8];
         2'h2: cio_get = {3'h0, v[20:16]};
         default: cio_get = {6'h00, v[22:21]};
      endcase
   endfunction : cio_get

   // replace one port inside a flat pin vector
   function automatic logic [22:0] cio_put(input logic [22:0] v, input logic [1:0] p,
                                          input logic [7:0] b);
      logic [22:0] r;
      r = v;
      case (p)
         2'h0: r[7:0] = b;
         2'h1: r[15:8] = b;
         2'h2: r[20:16] = b[4:0];
         default: r[22:21] = b[1:0];
      endcase
      cio_put = r;
   endfunction : cio_put

   // register decode: word index and port from the byte address
   assign idx = paddr[7:4];
   assign sub = paddr[3:2];
   assign hit = (idx <= `CIO_IDX_PINS) || (idx == `CIO_IDX_MISC && sub <= `CIO_SUB_STAT);
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite && ce && hit;

   // clock pins and the enabled reset pin are lost to i/o
   always_comb begin
      avail = '1;
      avail[`CIO_RST_PIN] = !opt_ext_reset;
      if (opt_clk_sel != `CIO_CLK_INT) begin
         avail[`CIO_XTAL1_PIN] = 1'b0;
      end
      if (opt_clk_sel >= `CIO_CLK_XTAL) begin // codes 2 and 3 are both crystal
         avail[`CIO_XTAL2_PIN] = 1'b0;
      end
   end

   // pin count: 23 internal osc down to 20 crystal plus reset pin
   always_comb begin
      pin_count = `CIO_MAX_PINS - {4'h0, opt_ext_reset};
      case (opt_clk_sel)
         `CIO_CLK_EXT: pin_count = pin_count - 5'h01;
         `CIO_CLK_INT: pin_count = pin_count;
         default: pin_count = pin_count - 5'h02; // both crystal codes
      endcase
   end

   // read path: digital input disable forces a zero, not the pad level
   always_comb begin
      rd_pins = s_q.s2 & avail;
      rd_pins[5:1] = rd_pins[5:1] & ~s_q.dis;
   end

   // pad drivers; the type code is {cfgb bit, cfga bit}
   for (genvar i = 0; i < `CIO_NPIN; i++) begin : g_pad
      cio_pkg::cio_mode_e m;
      assign m = avail[i] ? cio_pkg::cio_mode_e'({s_q.cfb[i], s_q.cfa[i]})
                          : cio_pkg::CIO_INPUT;
      always_comb begin
         pad.drv[i] = 1'b0;
         pad.oe[i] = 1'b0;
         pad.pu[i] = 1'b0;
         case (m)
            cio_pkg::CIO_QUASI: begin
               pad.oe[i] = !s_q.lat[i];
               pad.pu[i] = s_q.lat[i];
            end
            cio_pkg::CIO_OPEN: begin
               pad.oe[i] = !s_q.lat[i];
            end
            cio_pkg::CIO_PUSH: begin
               pad.oe[i] = 1'b1;
               pad.drv[i] = s_q.lat[i];
            end
            default: begin
               pad.oe[i] = 1'b0;
            end
         endcase
      end
   end
   assign pin_drv = pad.drv;
   assign pin_oe = pad.oe;
   assign pin_pu = pad.pu;

   // next state: synchroniser, register writes, read capture in setup
   always_comb begin
      s_d = s_q;
      s_d.s1 = pin_in;
      s_d.s2 = s_q.s1;
      if (wr) begin
         case (idx)
            `CIO_IDX_LATCH: s_d.lat = cio_put(s_q.lat, sub, pwdata[7:0]);
            // masks keep the reset pin input-only, i2c pins off quasi/push
            `CIO_IDX_CFGA: s_d.cfa = cio_put(s_q.cfa, sub, pwdata[7:0])
                                     & `CIO_CFA_MASK;
            `CIO_IDX_CFGB: s_d.cfb = cio_put(s_q.cfb, sub, pwdata[7:0])
                                     & `CIO_CFB_MASK;
            `CIO_IDX_MISC: begin
               if (sub == `CIO_SUB_DIS) begin
                  s_d.dis = pwdata[5:1];
               end
            end
            default: s_d.dis = s_q.dis;
         endcase
      end
      if (setup) begin
         case (idx)
            `CIO_IDX_LATCH: s_d.rdata = {24'h000000, cio_get(s_q.lat, sub)};
            `CIO_IDX_CFGA: s_d.rdata = {24'h000000, cio_get(s_q.cfa, sub)};
            `CIO_IDX_CFGB: s_d.rdata = {24'h000000, cio_get(s_q.cfb, sub)};
            `CIO_IDX_PINS: s_d.rdata = {24'h000000, cio_get(rd_pins, sub)};
            `CIO_IDX_MISC: begin
               if (sub == `CIO_SUB_DIS) begin
                  s_d.rdata = {26'h0000000, s_q.dis, 1'b0};
               end else if (sub == `CIO_SUB_STAT) begin
                  s_d.rdata = {16'h0000, 5'h00, opt_clk_sel, opt_ext_reset, 3'h0, pin_count};
               end else begin
                  s_d.rdata = 32'h00000000;
               end
            end
            default: s_d.rdata = 32'h00000000;
         endcase
      end
   end

   // state register; reset leaves every pin input-only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.lat <= `CIO_LAT_RESET;
         s_q.cfa <= `CIO_CFG_RESET;
         s_q.cfb <= `CIO_CFG_RESET;
         s_q.s1 <= '0;
         s_q.s2 <= '0;
         s_q.dis <= `CIO_DIS_RESET;
         s_q.rdata <= 32'h00000000;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // zero-wait answer; a frozen clock enable stalls the access
   assign pready = ce;
   assign pslverr = psel && penable && !hit;
   assign prdata = s_q.rdata;

   property p_rst_pin;
      @(posedge pclk) disable iff (!presetn)
      !pin_oe[`CIO_RST_PIN] && !pin_pu[`CIO_RST_PIN] && !s_q.cfa[`CIO_RST_PIN];
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin driven");

   property p_i2c;
      @(posedge pclk) disable iff (!presetn)
      (pin_pu[11:10] == 2'h0) && (pin_drv[11:10] == 2'h0);
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c pin not open-drain");

   property p_quasi;
      @(posedge pclk) disable iff (!presetn)
      (s_q.cfa[0] && !s_q.cfb[0]) |-> (pin_pu[0] == s_q.lat[0]) && (pin_oe[0] != s_q.lat[0])
                                       && !pin_drv[0];
   endproperty
   a_quasi: assert property (p_quasi) else $error("quasi pin wrong drive");

   property p_open;
      @(posedge pclk) disable iff (!presetn)
      (!s_q.cfa[1] && s_q.cfb[1]) |-> !pin_pu[1] && !pin_drv[1] && (pin_oe[1] == !s_q.lat[1]);
   endproperty
   a_open: assert property (p_open) else $error("open-drain pin wrong drive");

   property p_input;
      @(posedge pclk) disable iff (!presetn)
      (!s_q.cfa[2] && !s_q.cfb[2]) |-> !pin_oe[2] && !pin_pu[2];
   endproperty
   a_input: assert property (p_input) else $error("input-only pin driven");

   property p_push;
      @(posedge pclk) disable iff (!presetn)
      (s_q.cfa[3] && s_q.cfb[3]) |-> pin_oe[3] && (pin_drv[3] == s_q.lat[3]);
   endproperty
   a_push: assert property (p_push) else $error("push-pull pin wrong drive");

   property p_dis;
      @(posedge pclk) disable iff (!presetn)
      (setup && ce && idx == `CIO_IDX_PINS && sub == 2'h0 && s_q.dis[0]) |=> !prdata[1];
   endproperty
   a_dis: assert property (p_dis) else $error("disabled input read high");

   property p_idle;
      @(posedge pclk) disable iff (!presetn)
      (s_q.cfa == 23'h000000 && s_q.cfb == 23'h000000) |-> pin_oe == 23'h000000
                                                           && pin_pu == 23'h000000;
   endproperty
   a_idle: assert property (p_idle) else $error("unconfigured pin driven");

   property p_count;
      @(posedge pclk) disable iff (!presetn)
      (opt_clk_sel == `CIO_CLK_XTAL && opt_ext_reset) |-> pin_count == 5'h14;
   endproperty
   a_count: assert property (p_count) else $error("pin count wrong");

   property p_cfg_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == `CIO_IDX_CFGA && sub == 2'h0) |=> s_q.cfa[7:0] == $past(pwdata[7:0]);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr) else $error("config write lost");

   property p_lost;
      @(posedge pclk) disable iff (!presetn)
      ((~avail & (pin_oe | pin_pu)) == 23'h000000);
   endproperty
   a_lost: assert property (p_lost) else $error("lost pin driven");

   property p_rst_cfb;
      @(posedge pclk) disable iff (!presetn)
      !s_q.cfb[`CIO_RST_PIN];
   endproperty
   a_rst_cfb: assert property (p_rst_cfb) else $error("reset pin type set");

   property p_i2c_cfa;
      @(posedge pclk) disable iff (!presetn)
      !s_q.cfa[`CIO_SCL_PIN] && !s_q.cfa[`CIO_SDA_PIN];
   endproperty
   a_i2c_cfa: assert property (p_i2c_cfa) else $error("i2c pin type not allowed");

   property p_dis_wr;
      @(posedge pclk) disable iff (!presetn)
      (wr && idx == `CIO_IDX_MISC && sub == `CIO_SUB_DIS) |=> s_q.dis == $past(pwdata[5:1]);
   endproperty
   a_dis_wr: assert property (p_dis_wr) else $error("input disable write lost");

   property p_pu_excl;
      @(posedge pclk) disable iff (!presetn)
      (pin_pu & pin_oe) == 23'h000000;
   endproperty
   a_pu_excl: assert property (p_pu_excl) else $error("pull-up with strong drive");

endmodule : cio_ports

/* tb/cio_pad_model.sv */
// partner model: outside circuitry hanging on the port pads
`timescale 1ns/1ps
module cio_pad_model (
   // pad outputs of the block
   input wire logic [22:0] pin_drv,
   input wire logic [22:0] pin_oe,
   // outside driver set by the bench
   input wire logic [22:0] ext_en,
   input wire logic [22:0] ext_val,
   // resolved pad level
   output logic [22:0] pin_in
);
   // strong drive wins, then an outside driver, then board pull-up
   always_comb begin
      for (int i = 0; i < 23; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_drv[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else begin
            pin_in[i] = 1'b1; // resistor to supply on every line
         end
      end
   end
endmodule : cio_pad_model

/* tb/configurable_io_ports_tb_top.sv */
// self-checking bench of the configurable i/o ports
`timescale 1ns/1ps
module configurable_io_ports_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic opt_ext_reset = 1'b0;
   logic [1:0] opt_clk_sel = 2'h0;
   logic [22:0] pin_in, pin_drv, pin_oe, pin_pu;
   logic [22:0] ext_en = 23'h0;
   logic [22:0] ext_val = 23'h0;
   logic [32:0] exp_q[$];
   logic [32:0] exp_cur;
   logic [31:0] lfsr = 32'h63e4;
   logic [7:0] l, oe, pu, drv, lvl, r;
   logic [4:0] cnt;
   int err_total = 0;
   int compares = 0;

   always #25 pclk = ~pclk;

   cio_ports cio_ports_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .opt_ext_reset(opt_ext_reset),
      .opt_clk_sel(opt_clk_sel), .pin_in(pin_in), .pin_drv(pin_drv), .pin_oe(pin_oe),
      .pin_pu(pin_pu));
   cio_pad_model cio_pad_model_i (.pin_drv(pin_drv), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_in(pin_in));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd

   task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", name, e, s);
         err_total++;
      end
   endtask : check

   task automatic complete_run();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run

   // one apb transfer plus an idle edge, so no strobe is set twice in a step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      if (!wr) exp_q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_total++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // read results are matched against the oldest queued note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         exp_cur = exp_q.pop_front();
         check("prdata", exp_cur[31:0], prdata);
         check("pslverr", {31'h0, exp_cur[32]}, {31'h0, pslverr});
      end
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      complete_run();
   end

   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("oe", 32'h0, {9'h0, pin_oe | pin_pu | pin_drv});
      for (int i = 0; i < 4; i++) begin
         r = (i < 2) ? 8'hff : ((i == 2) ? 8'h1f : 8'h03);
         apb(1'b0, 8'(i * 4), 32'h0, {25'h0, r});
         apb(1'b0, 8'(8'h10 + i * 4), 32'h0, 33'h0);
         apb(1'b0, 8'(8'h20 + i * 4), 32'h0, 33'h0);
      end
      // every type on port 0, random latch and outside drive
      for (int m = 0; m < 4; m++) begin
         l = 8'(rnd());
         r = 8'(rnd());
         ext_en[7:0] <= r;
         ext_val[7:0] <= 8'(rnd());
         apb(1'b1, 8'h00, {24'h0, l}, 33'h0);
         apb(1'b1, 8'h10, {24'h0, {8{m[0]}}}, 33'h0);
         apb(1'b1, 8'h20, {24'h0, {8{m[1]}}}, 33'h0);
         oe = (m == 1 || m == 2) ? ~l : ((m == 3) ? 8'hff : 8'h00);
         pu = (m == 1) ? l : 8'h00;
         drv = (m == 3) ? l : 8'h00;
         check("oe", {24'h0, oe}, {9'h0, pin_oe});
         check("pu", {24'h0, pu}, {9'h0, pin_pu});
         check("drv", {24'h0, drv}, {9'h0, pin_drv});
         lvl = (oe & drv) | (~oe & ((r & ext_val[7:0]) | ~r));
         repeat (3) @(posedge pclk);
         apb(1'b0, 8'h30, 32'h0, {25'h0, lvl});
      end
      // restricted pins of port 1
      apb(1'b1, 8'h14, 32'hff, 33'h0);
      apb(1'b1, 8'h24, 32'hff, 33'h0);
      apb(1'b1, 8'h04, 32'h00, 33'h0);
      apb(1'b0, 8'h14, 32'h0, 33'hd3);
      apb(1'b0, 8'h24, 32'h0, 33'hdf);
      check("oe1", 32'hdf, {24'h0, pin_oe[15:8]});
      // digital input disable on port 0, still in push-pull
      ext_en <= 23'h0;
      r = 8'(rnd()) | 8'h02; // pin 1 always disabled, so the read-back guard sees it
      apb(1'b1, 8'h40, {24'h0, r}, 33'h0);
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h30, 32'h0, {25'h0, l & ~(r & 8'h3e)});
      // analog use: software turns the port 0 drivers off first
      apb(1'b1, 8'h10, 32'h0, 33'h0);
      apb(1'b1, 8'h20, 32'h0, 33'h0);
      check("oe0", 32'h0, {24'h0, pin_oe[7:0] | pin_pu[7:0]});
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h40, 32'h0, {25'h0, r & 8'h3e});
      apb(1'b0, 8'h30, 32'h0, {25'h0, ~(r & 8'h3e)});
      // usable pin count for every option pair
      for (int e = 0; e < 2; e++) begin
         for (int c = 0; c < 4; c++) begin
            opt_ext_reset <= e[0];
            opt_clk_sel <= c[1:0];
            cnt = 5'(23 - e - ((c == 1) ? 1 : ((c >= 2) ? 2 : 0)));
            apb(1'b0, 8'h44, 32'h0, {22'h0, c[1:0], e[0], 3'h0, cnt});
            // clock pins lost to the option read zero on port 3
            apb(1'b0, 8'h3c, 32'h0,
                {31'h0, (c == 0) ? 2'h3 : ((c == 1) ? 2'h1 : 2'h0)});
         end
      end
      apb(1'b0, 8'h48, 32'h0, {1'b1, 32'h0});
      // second reset clears types and the disable bits
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 8'h30, 32'h0, 33'hff);
      complete_run();
   end
endmodule : configurable_io_ports_tb_top
